// ---- verilog/line_modem_pkg.sv ----
// Package: register map, field positions and shared types of line/modem control
`default_nettype none
package line_modem_pkg;

	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_INT = 3'h1;
	localparam logic [2:0] OFS_LINE = 3'h3;
	localparam logic [2:0] OFS_MODEM = 3'h4;
	localparam logic [2:0] OFS_STAT = 3'h6;
	localparam logic [2:0] OFS_SCR = 3'h7;

	localparam logic [7:0] LINE_RESET = 8'h1D;
	localparam logic [7:0] MODEM_RESET = 8'h00;
	localparam logic [7:0] DIV_RESET = 8'h01;
	localparam logic [7:0] SCR_RESET = 8'h00;
	localparam logic [7:0] MODEM_GUARD = 8'hEC;

	localparam int LC_DLAB = 7;
	localparam int LC_BREAK = 6;
	localparam int LC_FORCE = 5;
	localparam int LC_EVEN = 4;
	localparam int LC_PAR = 3;
	localparam int LC_STOP = 2;
	localparam int MC_PRESC = 7;
	localparam int MC_IR = 6;
	localparam int MC_ANY = 5;
	localparam int MC_LOOP = 4;
	localparam int MC_OUT2 = 3;
	localparam int MC_OUT1 = 2;
	localparam int MC_RTS = 1;
	localparam int MC_DTR = 0;

	localparam logic [1:0] PRESC_DIV = 2'h3;
	localparam logic [4:0] IR_PULSE = 5'h03;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_START = 3'h1,
		TX_DATA = 3'h3,
		TX_PARITY = 3'h2,
		TX_STOP = 3'h6
	} tx_state_e;

	typedef struct packed {
		logic [2:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic rts_n;
		logic dtr_n;
		logic tx;
	} modem_pins_s;

	typedef struct packed {
		logic cts;
		logic dsr;
		logic ri;
		logic dcd;
	} modem_in_s;

endpackage : line_modem_pkg
`default_nettype wire

// ---- verilog/byte_fifo.sv ----
// Small FIFO with valid/ready on both sides
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clock, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic in_valid, // Write request
	output logic in_ready, // Not full
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Not empty
	input wire logic out_ready, // Read accept
	output logic [WIDTH-1:0] out_data // Head word, registered
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic [WIDTH-1:0] head;
	} fifo_s;

	fifo_s st_q, st_d;
	logic push, pop;

	assign in_ready = st_q.cnt != (AW+1)'(DEPTH);
	assign out_valid = st_q.cnt != '0;
	assign out_data = st_q.head;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		st_d = st_q;
		if (push)
		begin
			st_d.mem[st_q.wp] = in_data;
			st_d.wp = st_q.wp + 1'b1;
		end
		if (pop)
			st_d.rp = st_q.rp + 1'b1;
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		st_d.head = st_d.mem[st_d.rp];
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			st_q <= '0;
		else if (ce)
			st_q <= st_d;
	end
endmodule : byte_fifo
`default_nettype wire

// ---- verilog/char_format.sv ----
// Character framing helpers: frame length and parity bit
`default_nettype none
module char_format
	import line_modem_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic [7:0] line_cfg, // Line control value
	input wire logic [7:0] data, // Character to frame
	output logic [3:0] nbits, // Data bits per character
	output logic par_bit, // Parity bit value
	output logic [2:0] stop_half // Stop length in half bits
);
	typedef struct packed {
		logic [3:0] nbits;
		logic par;
		logic [2:0] stop_half;
	} fmt_s;

	fmt_s st_q, st_d;

	function automatic logic [7:0] len_mask(input logic [1:0] wl);
		len_mask = 8'hFF >> (2'h3 - wl);
	endfunction : len_mask

	always_comb
	begin
		st_d.nbits = 4'h5 + {2'h0, line_cfg[1:0]}; // RULE7
		if (!line_cfg[LC_STOP])
			st_d.stop_half = 3'h2; // RULE6
		else if (line_cfg[1:0] == 2'h0)
			st_d.stop_half = 3'h3; // RULE6
		else
			st_d.stop_half = 3'h4; // RULE6
		if (line_cfg[LC_FORCE])
			st_d.par = !line_cfg[LC_EVEN]; // RULE3
		else
			st_d.par = ^(data & len_mask(line_cfg[1:0]))
				^ !line_cfg[LC_EVEN]; // RULE4
	end

	assign nbits = st_q.nbits;
	assign par_bit = st_q.par;
	assign stop_half = st_q.stop_half;

	always_ff @(posedge clock)
	begin
		if (rst)
			st_q <= '0;
		else if (ce)
			st_q <= st_d;
	end
endmodule : char_format
`default_nettype wire

// ---- verilog/line_modem_ctrl.sv ----
// Line and modem control registers with a simple serial transmitter
`default_nettype none

// Notes on behaviour
// RULE1: Line bit 7 opens divisor latch access
// RULE2: Line bit 6 holds serial output low; in loopback the pin stays high and only the looped receive line goes low
// RULE3: Forced parity: one if bit4 low
// RULE4: Bit 4 picks odd or even parity
// RULE5: Parity added and checked only when bit3
// RULE6: Bit 2 gives 1, 1.5 or 2 stops; the transmitter sends whole stop bits, so the 1.5 setting gives 2
// RULE7: Bits 1:0 give five to eight bits
// RULE8: Modem control reachable only with latch closed
// RULE9: Modem bit 7 divides clock by four
// RULE10: Modem bit 6 selects infrared encoding
// RULE11: Modem bit 5: any character resumes transmit
// RULE12: Any-mode stores characters except flow characters
// RULE13: Loopback routes transmit to receive, status
// RULE14: Modem bit 3 is internal carrier detect
// RULE15: Modem bit 2 ring or register select
// RULE16: Modem bit 1 drives request-to-send inverted
// RULE17: Modem bit 0 drives terminal-ready inverted
// RULE18: Guarded modem bits need enhanced feature bit
// RULE19: Line control at 03h resets to 1Dh
// RULE20: Latch open maps low offsets to divisor
module line_modem_ctrl
	import line_modem_pkg::*;
#(
	parameter int BAUD_DIV = 16,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clock, // System clock, 100 MHz
	input wire logic rst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire line_modem_pkg::reg_req_s req, // Register access
	output logic [7:0] rdata, // Read data, one cycle after rd
	input wire logic enhanced_en, // Enhanced feature bit 4
	input wire logic auto_rts, // Hardware flow control of RTS
	input wire logic hw_rts_n, // RTS value under auto control
	input wire logic dtr_pin_sel, // General pin configured as DTR
	input wire logic sw_flow_rx, // Receive software flow enabled
	input wire logic sw_halted, // Transmit halted by flow control
	input wire logic rx_char_valid, // Received character strobe
	input wire logic [7:0] rx_char, // Received character
	input wire logic rx_is_flow_char, // Character is Xon/Xoff
	input wire logic rx_pin, // Serial receive pin
	input wire line_modem_pkg::modem_in_s modem_pins, // Modem inputs
	output logic rx_store_valid, // Character to receive FIFO
	output logic [7:0] rx_store_data, // Stored character
	output logic rx_line, // Receive stream after loopback
	output logic resume_tx, // Pulse releasing halted transmit
	output logic parity_check_en, // Receive parity checking enable
	output logic [7:0] line_status, // Modem status: DCD, RI, DSR, CTS in bits 7:4
	output line_modem_pkg::modem_pins_s pins_out // Serial modem pins
);
	// ----------------------------------------------------------
	// State
	// ----------------------------------------------------------
	typedef struct packed {
		logic [7:0] line_q;
		logic [7:0] modem_q;
		logic [7:0] div_lo;
		logic [7:0] div_hi;
		logic [7:0] scr;
		logic [7:0] rdata;
		logic [1:0] presc;
		logic [15:0] baud_cnt;
		logic tick;
		tx_state_e tx_st;
		logic [7:0] tx_sh;
		logic [3:0] bit_idx;
		logic [2:0] half_cnt;
		logic half_ph;
		logic [4:0] ir_cnt;
		logic tx_raw;
		modem_pins_s pins;
		logic rx_line;
		logic resume;
		logic st_valid;
		logic [7:0] st_data;
		logic [1:0] rx_s1;
		modem_in_s m_s1;
		modem_in_s m_s2;
		logic [7:0] modem_status;
		logic fifo_take;
	} ctrl_s;

	ctrl_s st_q, st_d;
	logic fifo_ready, fifo_valid;
	logic [7:0] fifo_data;
	logic [3:0] nbits;
	logic par_bit;
	logic [2:0] stop_half;
	logic dlab, loop;
	logic rx_sync;

	assign dlab = st_q.line_q[LC_DLAB];
	assign loop = st_q.modem_q[MC_LOOP];
	assign rx_sync = st_q.rx_s1[1];

	// ----------------------------------------------------------
	// Transmit data buffer and framing
	// ----------------------------------------------------------
	byte_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.in_valid(req.wr && req.addr == OFS_DATA && !dlab),
		.in_ready(fifo_ready),
		.in_data(req.wdata),
		.out_valid(fifo_valid),
		.out_ready(st_q.fifo_take),
		.out_data(fifo_data)
	);

	char_format u_fmt (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.line_cfg(st_q.line_q),
		.data(st_q.tx_sh),
		.nbits(nbits),
		.par_bit(par_bit),
		.stop_half(stop_half)
	);

	function automatic logic [7:0] guard(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic en);
		guard = en ? new_v : ((old_v & MODEM_GUARD) | (new_v & ~MODEM_GUARD));
	endfunction : guard

	always_comb
	begin
		st_d = st_q;
		st_d.resume = 1'b0;
		st_d.st_valid = 1'b0;
		st_d.fifo_take = 1'b0;
		st_d.tick = 1'b0;
		st_d.rx_s1 = {st_q.rx_s1[0], rx_pin};
		st_d.m_s1 = modem_pins;
		st_d.m_s2 = st_q.m_s1;

		// ------------------------------------------------------
		// Register writes
		// ------------------------------------------------------
		if (req.wr)
		begin
			if (req.addr == OFS_LINE)
				st_d.line_q = req.wdata; // RULE19
			else if (req.addr == OFS_DATA && dlab)
				st_d.div_lo = req.wdata; // RULE1 RULE20
			else if (req.addr == OFS_INT && dlab)
				st_d.div_hi = req.wdata; // RULE20
			else if (req.addr == OFS_MODEM && !dlab)
				st_d.modem_q = guard(st_q.modem_q, req.wdata,
					enhanced_en); // RULE8 RULE18
			else if (req.addr == OFS_SCR && !dlab && !st_q.modem_q[MC_OUT1])
				st_d.scr = req.wdata; // RULE15
		end

		// ------------------------------------------------------
		// Register reads
		// ------------------------------------------------------
		if (req.rd)
		begin
			if (req.addr == OFS_LINE)
				st_d.rdata = st_q.line_q;
			else if (req.addr == OFS_DATA && dlab)
				st_d.rdata = st_q.div_lo; // RULE20
			else if (req.addr == OFS_INT && dlab)
				st_d.rdata = st_q.div_hi; // RULE20
			else if (req.addr == OFS_MODEM && !dlab)
				st_d.rdata = st_q.modem_q; // RULE8
			else if (req.addr == OFS_STAT && !dlab && !st_q.modem_q[MC_OUT1])
				st_d.rdata = st_q.modem_status; // RULE15
			else if (req.addr == OFS_SCR && !dlab && !st_q.modem_q[MC_OUT1])
				st_d.rdata = st_q.scr; // RULE15
			else
				st_d.rdata = 8'h00;
		end

		// ------------------------------------------------------
		// Modem status, loopback feeds
		// ------------------------------------------------------
		if (loop)
			st_d.modem_status = {st_q.modem_q[MC_OUT2], st_q.modem_q[MC_OUT1],
				st_q.modem_q[MC_DTR], st_q.modem_q[MC_RTS],
				4'h0}; // RULE13 RULE14 RULE15 RULE16 RULE17
		else
			st_d.modem_status = {st_q.m_s2.dcd, st_q.m_s2.ri, st_q.m_s2.dsr,
				st_q.m_s2.cts, 4'h0};

		// ------------------------------------------------------
		// Prescaler and baud tick
		// ------------------------------------------------------
		st_d.presc = st_q.presc + 2'h1;
		if (!st_q.modem_q[MC_PRESC] || st_q.presc == PRESC_DIV) // RULE9
		begin
			if (st_q.baud_cnt >= 16'(BAUD_DIV - 1))
			begin
				st_d.baud_cnt = 16'h0000;
				st_d.tick = 1'b1;
			end
			else
				st_d.baud_cnt = st_q.baud_cnt + 16'h0001;
		end

		// ------------------------------------------------------
		// Transmitter
		// ------------------------------------------------------
		if (st_q.tick)
		begin
			case (st_q.tx_st)
				TX_IDLE:
				begin
					st_d.tx_raw = 1'b1;
					if (fifo_valid && !sw_halted)
					begin
						st_d.tx_sh = fifo_data;
						st_d.fifo_take = 1'b1;
						st_d.tx_st = TX_START;
					end
				end
				TX_START:
				begin
					st_d.tx_raw = 1'b0;
					st_d.bit_idx = 4'h0;
					st_d.tx_st = TX_DATA;
				end
				TX_DATA:
				begin
					st_d.tx_raw = st_q.tx_sh[st_q.bit_idx[2:0]];
					st_d.bit_idx = st_q.bit_idx + 4'h1;
					if (st_q.bit_idx == nbits - 4'h1) // RULE7
						st_d.tx_st = st_q.line_q[LC_PAR] ? TX_PARITY
							: TX_STOP; // RULE5
					st_d.half_cnt = 3'h0;
					st_d.half_ph = 1'b0;
				end
				TX_PARITY:
				begin
					st_d.tx_raw = par_bit; // RULE3 RULE4 RULE5
					st_d.tx_st = TX_STOP;
				end
				TX_STOP:
				begin
					st_d.tx_raw = 1'b1;
					st_d.half_cnt = st_q.half_cnt + 3'h2;
					if (st_q.half_cnt + 3'h2 >= stop_half) // RULE6
						st_d.tx_st = TX_IDLE;
				end
				default:
					st_d.tx_st = TX_IDLE;
			endcase
		end

		// Infrared: short high pulse for each zero bit
		if (st_q.tick)
			st_d.ir_cnt = IR_PULSE;
		else if (st_q.ir_cnt != 5'h00)
			st_d.ir_cnt = st_q.ir_cnt - 5'h01;

		// ------------------------------------------------------
		// Pins
		// ------------------------------------------------------
		if (loop)
			st_d.pins.tx = 1'b1; // RULE13
		else if (st_q.line_q[LC_BREAK])
			st_d.pins.tx = 1'b0; // RULE2
		else if (st_q.modem_q[MC_IR])
			st_d.pins.tx = !st_q.tx_raw && st_q.ir_cnt != 5'h00; // RULE10
		else
			st_d.pins.tx = st_q.tx_raw;
		st_d.pins.rts_n = (auto_rts && !loop) ? hw_rts_n
			: (loop ? 1'b1 : !st_q.modem_q[MC_RTS]); // RULE16
		st_d.pins.dtr_n = (dtr_pin_sel && !loop)
			? !st_q.modem_q[MC_DTR] : 1'b1; // RULE17
		st_d.rx_line = loop ? (st_q.tx_raw && !st_q.line_q[LC_BREAK])
			: rx_sync; // RULE13

		// ------------------------------------------------------
		// Resume on any character and receive storage
		// ------------------------------------------------------
		if (rx_char_valid)
		begin
			st_d.resume = st_q.modem_q[MC_ANY] && sw_halted; // RULE11
			st_d.st_valid = !(sw_flow_rx && rx_is_flow_char); // RULE12
			st_d.st_data = rx_char;
		end
	end

	assign rdata = st_q.rdata;
	assign pins_out = st_q.pins;
	assign rx_line = st_q.rx_line;
	assign resume_tx = st_q.resume;
	assign rx_store_valid = st_q.st_valid;
	assign rx_store_data = st_q.st_data;
	assign parity_check_en = st_q.line_q[LC_PAR]; // RULE5
	assign line_status = st_q.modem_status;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st_q <= '0;
			st_q.line_q <= LINE_RESET; // RULE19
			st_q.modem_q <= MODEM_RESET;
			st_q.div_lo <= DIV_RESET;
			st_q.scr <= SCR_RESET;
			st_q.tx_raw <= 1'b1;
			st_q.pins <= '1;
			st_q.rx_line <= 1'b1;
			st_q.rx_s1 <= 2'h3;
		end
		else if (ce)
			st_q <= st_d;
	end

	logic unused_ready;
	assign unused_ready = fifo_ready;
endmodule : line_modem_ctrl
`default_nettype wire

// ---- bench/line_modem_asserts.sv ----
// Port checker for line and modem control
`default_nettype none
module line_modem_asserts
	import line_modem_pkg::*;
(
	input wire logic clock, // Clock
	input wire logic rst, // Reset
	input wire line_modem_pkg::reg_req_s req, // Register access
	input wire logic [7:0] rdata, // Read data
	input wire logic auto_rts, // Auto RTS
	input wire logic hw_rts_n, // Hardware RTS
	input wire logic dtr_pin_sel, // DTR select
	input wire logic sw_flow_rx, // Flow enable
	input wire logic sw_halted, // Halted
	input wire logic rx_char_valid, // Char strobe
	input wire logic [7:0] rx_char, // Char
	input wire logic rx_is_flow_char, // Flow char
	input wire logic rx_store_valid, // Store strobe
	input wire logic [7:0] rx_store_data, // Stored char
	input wire logic resume_tx, // Resume pulse
	input wire line_modem_pkg::modem_pins_s pins_out // Pins
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// ----------------
	// Properties
	// ----------------
	a_store_next: assert property (
		rx_char_valid && !(sw_flow_rx && rx_is_flow_char) |=>
		rx_store_valid && rx_store_data == $past(rx_char))
		else $error("char not stored");
	a_flow_drop: assert property (
		rx_char_valid && sw_flow_rx && rx_is_flow_char |=> !rx_store_valid)
		else $error("flow char stored");
	a_store_cause: assert property (
		rx_store_valid |-> $past(rx_char_valid))
		else $error("store without char");
	a_resume_cause: assert property (
		resume_tx |-> $past(rx_char_valid) && $past(sw_halted))
		else $error("resume without cause");
	a_dtr_unused: assert property (
		!dtr_pin_sel && !$past(dtr_pin_sel) |-> pins_out.dtr_n)
		else $error("dtr driven while unselected");
	a_rts_hw: assert property (
		!pins_out.rts_n && $past(auto_rts) |-> !$past(hw_rts_n))
		else $error("rts low against hardware");
	a_reset_value: assert property (
		$past(rst) |-> pins_out == 3'h7 && rdata == 8'h00)
		else $error("reset values wrong");
	a_rdata_hold: assert property (
		!$past(req.rd) && !$past(rst) |-> $stable(rdata))
		else $error("read data moved");
	c_store: cover property (rx_char_valid ##1 rx_store_valid);
	c_resume: cover property (resume_tx);
	c_rts_hw: cover property (auto_rts ##1 !pins_out.rts_n);
endmodule : line_modem_asserts
`default_nettype wire

// ---- bench/modem_far.sv ----
// Behavioural modem at the far side of the serial pins
`default_nettype none
module modem_far
	import line_modem_pkg::*;
(
	input wire line_modem_pkg::modem_pins_s pins, // Device pins
	input wire logic carrier, // Carrier present
	output line_modem_pkg::modem_in_s st, // Status lines
	output logic rx // Echo of transmit
);
	timeunit 1ns;
	timeprecision 1ps;
	// Ready to take data while request is asserted
	always_comb
	begin
		st.cts = !pins.rts_n;
		st.dsr = 1'b1;
		st.ri = 1'b0;
		st.dcd = carrier;
		rx = pins.tx;
	end
endmodule : modem_far
`default_nettype wire

// ---- bench/test_line_modem_ctrl.sv ----
// Self-checking bench of line and modem control
`default_nettype none
module test_line_modem_ctrl;
	import line_modem_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rst = 1, ce = 1, carrier = 0;
	reg_req_s req = '0;
	logic enhanced_en = 0, auto_rts = 0, hw_rts_n = 1, dtr_pin_sel = 1;
	logic sw_flow_rx = 0, sw_halted = 0, rx_char_valid = 0;
	logic rx_is_flow_char = 0, rx_pin, rx_store_valid, rx_line;
	logic resume_tx, parity_check_en, ex;
	logic [7:0] rx_char = 0, rdata, rx_store_data, line_status, m, v;
	modem_in_s modem_pins;
	modem_pins_s pins_out;
	int failures = 0, n_compared = 0, i, k;
	line_modem_ctrl #(.BAUD_DIV(2)) u_line_modem_ctrl (.clock, .rst, .ce,
		.req, .rdata, .enhanced_en, .auto_rts, .hw_rts_n, .dtr_pin_sel,
		.sw_flow_rx, .sw_halted, .rx_char_valid, .rx_char, .rx_is_flow_char,
		.rx_pin, .modem_pins, .rx_store_valid, .rx_store_data, .rx_line,
		.resume_tx, .parity_check_en, .line_status, .pins_out);
	modem_far u_modem_far (.pins(pins_out), .carrier, .st(modem_pins),
		.rx(rx_pin));
	always #5 clock = ~clock;
	// ----------------
	// Helpers
	// ----------------
	task automatic give_verdict;
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clock);
		req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge clock);
		req.wr = 1'b0;
	endtask : wr
	task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
		@(negedge clock);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge clock);
		req.rd = 1'b0;
		@(negedge clock);
		chk(rdata, exp);
	endtask : rchk
	task automatic frame_chk(input logic [7:0] lc, input logic [7:0] d,
		input int per);
		int j, t;
		logic p;
		wr(OFS_LINE, lc);
		wr(OFS_DATA, d);
		p = 1'b0;
		t = 0;
		while (pins_out.tx !== 1'b0 && t < 200)
		begin
			@(negedge clock);
			t++;
		end
		chk({7'h0, pins_out.tx}, 8'h00);
		repeat (per / 2) @(negedge clock);
		for (j = 0; j < 5 + lc[1:0]; j++)
		begin
			repeat (per) @(negedge clock);
			chk({7'h0, pins_out.tx}, {7'h0, d[j]});
			p ^= d[j];
		end
		if (lc[3])
		begin
			p = lc[5] ? !lc[4] : (p ^ !lc[4]);
			repeat (per) @(negedge clock);
			chk({7'h0, pins_out.tx}, {7'h0, p});
		end
		repeat (per) @(negedge clock);
		chk({7'h0, pins_out.tx}, 8'h01);
	endtask : frame_chk
	function automatic logic [7:0] mc_exp(logic [7:0] o, n, logic en);
		return en ? n : (o & MODEM_GUARD) | (n & ~MODEM_GUARD);
	endfunction : mc_exp
	function automatic logic [3:0] st_exp(logic [7:0] mc, logic cd);
		return mc[4] ? {mc[3], mc[2], mc[0], mc[1]} : {cd, 2'b01, mc[1]};
	endfunction : st_exp
	// ----------------
	// Tests
	// ----------------
	initial
	begin
		void'($urandom(10));
		repeat (2) @(negedge clock);
		rst = 0;
		rchk(OFS_LINE, LINE_RESET);
		rchk(OFS_MODEM, MODEM_RESET);
		wr(OFS_LINE, 8'h80);
		rchk(OFS_DATA, DIV_RESET);
		rchk(OFS_INT, 8'h00);
		wr(OFS_DATA, 8'h5A);
		rchk(OFS_DATA, 8'h5A);
		wr(OFS_DATA, DIV_RESET);
		wr(OFS_MODEM, 8'h03);
		wr(OFS_LINE, 8'h00);
		rchk(OFS_MODEM, 8'h00);
		repeat (6)
		begin
			v = 8'($urandom) & 8'h3F;
			wr(OFS_LINE, v);
			rchk(OFS_LINE, v);
			chk({7'h0, parity_check_en}, {7'h0, v[3]});
		end
		wr(OFS_LINE, 8'h43);
		repeat (6) @(negedge clock);
		chk({7'h0, pins_out.tx}, 8'h00);
		chk({7'h0, rx_line}, 8'h00);
		wr(OFS_MODEM, 8'h10);
		repeat (6) @(negedge clock);
		chk({7'h0, pins_out.tx}, 8'h01);
		chk({7'h0, rx_line}, 8'h00);
		wr(OFS_MODEM, 8'h00);
		wr(OFS_LINE, 8'h03);
		repeat (6) @(negedge clock);
		chk({7'h0, pins_out.tx}, 8'h01);
		chk({7'h0, rx_line}, 8'h01);
		m = MODEM_RESET;
		for (i = 0; i < 10; i++)
		begin
			v = (i == 0) ? 8'hFF : (i == 1) ? 8'h1B : 8'($urandom);
			enhanced_en = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($urandom);
			carrier = 1'($urandom);
			m = mc_exp(m, v, enhanced_en);
			wr(OFS_MODEM, v);
			rchk(OFS_MODEM, m);
			repeat (6) @(negedge clock);
			chk({7'h0, pins_out.rts_n}, {7'h0, m[4] | !m[1]});
			chk({7'h0, pins_out.dtr_n}, {7'h0, m[4] | !m[0]});
			chk({4'h0, line_status[7:4]}, {4'h0, st_exp(m, carrier)});
		end
		enhanced_en = 1;
		@(negedge clock);
		rst = 1;
		@(negedge clock);
		rst = 0;
		rchk(OFS_LINE, LINE_RESET);
		rchk(OFS_STAT, {carrier, 3'b010, 4'h0});
		wr(OFS_SCR, 8'h3C);
		rchk(OFS_SCR, 8'h3C);
		wr(OFS_MODEM, 8'h04);
		rchk(OFS_SCR, 8'h00);
		rchk(OFS_STAT, 8'h00);
		for (k = 0; k < 2; k++)
		begin
			wr(OFS_MODEM, k ? 8'h00 : 8'h20);
			repeat (12)
			begin
				@(negedge clock);
				rx_char_valid = 1;
				rx_char = 8'($urandom);
				rx_is_flow_char = 1'($urandom);
				sw_flow_rx = 1'($urandom);
				sw_halted = 1'($urandom);
				auto_rts = 1'($urandom);
				hw_rts_n = 1'($urandom);
				dtr_pin_sel = 1'($urandom);
				ex = !(sw_flow_rx && rx_is_flow_char);
				@(negedge clock);
				rx_char_valid = 0;
				chk({7'h0, rx_store_valid}, {7'h0, ex});
				if (ex)
					chk(rx_store_data, rx_char);
				chk({7'h0, resume_tx}, {7'h0, sw_halted && !k});
			end
		end
		sw_halted = 0;
		frame_chk(8'h03, 8'hA5, 2);
		wr(OFS_MODEM, 8'h80);
		frame_chk(8'h1B, 8'($urandom), 8);
		wr(OFS_MODEM, 8'h00);
		frame_chk(8'h3A, 8'($urandom), 2);
		wr(OFS_MODEM, 8'h40);
		repeat (3) @(negedge clock);
		chk({7'h0, pins_out.tx}, 8'h00);
		give_verdict;
	end
	initial
	begin
		repeat (20000) @(posedge clock);
		failures++;
		give_verdict;
	end
endmodule : test_line_modem_ctrl
bind line_modem_ctrl line_modem_asserts u_line_modem_asserts (.clock, .rst,
	.req, .rdata, .auto_rts, .hw_rts_n, .dtr_pin_sel, .sw_flow_rx, .sw_halted,
	.rx_char_valid, .rx_char, .rx_is_flow_char, .rx_store_valid,
	.rx_store_data, .resume_tx, .pins_out);
`default_nettype wire
